// ---- tpts_params.svh ----
// Constants of the test pattern timing scroller.
// Included by the package and by the pattern generator.
`ifndef TPTS_PARAMS_SVH
`define TPTS_PARAMS_SVH
`define TPTS_TW 12
`define TPTS_SLOTS 16
`define TPTS_FIFO_DEPTH 16
`define TPTS_PIPE_MARGIN 4
`define TPTS_MASK18 8'hfc
`define TPTS_FULL_SCALE 8'hff
`define TPTS_GRAD_STEP 12'h100
`endif

// ---- tpts_pkg.sv ----
// Types shared by the test pattern timing scroller modules.
// Assumes tpts_params.svh sits in the include path.
`include "tpts_params.svh"
package tpts_pkg;
    typedef enum logic [1:0] {
        TPTS_TIMING_EXT,
        TPTS_TIMING_INT,
        TPTS_TIMING_INT_ECLK
    } tpts_mode_t;

    // Encodings follow pattern numbers 1 to 17; zero selects black.
    typedef enum logic [4:0] {
        TPTS_P_NONE, TPTS_P_WHITE, TPTS_P_BLACK, TPTS_P_RED, TPTS_P_GREEN,
        TPTS_P_BLUE, TPTS_P_HGRAY, TPTS_P_HRED, TPTS_P_HGREEN, TPTS_P_HBLUE,
        TPTS_P_VGRAY, TPTS_P_VRED, TPTS_P_VGREEN, TPTS_P_VBLUE,
        TPTS_P_CUSTOM, TPTS_P_CHECKER, TPTS_P_VCOM, TPTS_P_BARS
    } tpts_pat_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } tpts_rgb_t;

    typedef struct packed {
        logic pixel_valid;
        logic horizontal_sync;
        logic vertical_sync;
    } tpts_ctl_t;

    typedef struct packed {
        tpts_rgb_t rgb;
        tpts_ctl_t ctl;
    } tpts_pix_t;

    typedef struct packed {
        logic [`TPTS_TW-1:0] h_active;
        logic [`TPTS_TW-1:0] h_front;
        logic [`TPTS_TW-1:0] h_sync;
        logic [`TPTS_TW-1:0] h_back;
        logic [`TPTS_TW-1:0] v_active;
        logic [`TPTS_TW-1:0] v_front;
        logic [`TPTS_TW-1:0] v_sync;
        logic [`TPTS_TW-1:0] v_back;
    } tpts_timing_cfg_t;
endpackage

// ---- tpts_fifo.sv ----
// Synchronous FIFO of flip-flops with valid and ready on both sides.
// Assumes DEPTH is a power of two and a reset already synchronised.
`timescale 1ns/100ps
module tpts_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } tpts_fifo_state_t;

    tpts_fifo_state_t st;
    tpts_fifo_state_t next_st;
    logic full;
    logic empty;

    always_comb
    begin
        full = (st.wp ^ st.rp) == {1'b1, {AW{1'b0}}};
        empty = st.wp == st.rp;
        next_st = st;
        if (in_valid_in && !full)
        begin
            next_st.mem[st.wp[AW-1:0]] = in_data_in;
            next_st.wp = st.wp + 1'b1;
        end
        if (out_ready_in && !empty)
        begin
            next_st.rp = st.rp + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = st.mem[st.rp[AW-1:0]];
    assign level_out = st.wp - st.rp;
endmodule

// ---- tpts_pattern_gen.sv ----
// Test pattern generator with external or internal frame timing.
// Assumes video inputs and control ports run on clk_in; the external
// pixel clock is an asynchronous pin and is synchronised here.
`timescale 1ns/100ps
`include "tpts_params.svh"
module tpts_pattern_gen #(
    parameter int SLOTS = `TPTS_SLOTS,
    parameter int DEPTH = `TPTS_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ext_pixel_clock_in,
    input wire logic pixel_valid_in,
    input wire logic horizontal_sync_in,
    input wire logic vertical_sync_in,
    output logic upstream_ready_out,
    input wire tpts_pkg::tpts_mode_t timing_mode_in,
    input wire tpts_pkg::tpts_timing_cfg_t timing_cfg_in,
    input wire logic pattern_invert_bit_in,
    input wire logic color_18bit_in,
    input wire logic auto_scroll_in,
    input wire tpts_pkg::tpts_pat_t pattern_select_control_in,
    input wire logic [$clog2(SLOTS)-1:0] scroll_sequence_control_in,
    input wire logic [7:0] scroll_frames_in,
    input wire tpts_pkg::tpts_pat_t [SLOTS-1:0] scroll_order_slots_in,
    input wire logic [7:0] custom_red_level_in,
    input wire logic [7:0] custom_green_level_in,
    input wire logic [7:0] custom_blue_level_in,
    input wire logic link_ready_in,
    output tpts_pkg::tpts_pix_t video_out,
    output logic video_valid_out,
    output logic [`TPTS_TW-1:0] frame_width_out,
    output logic [`TPTS_TW-1:0] frame_height_out
);
    localparam int TW = `TPTS_TW;
    localparam int SW = $clog2(SLOTS);
    localparam int LW = $clog2(DEPTH) + 1;
    localparam int PW = $bits(tpts_pkg::tpts_pix_t);

    typedef struct packed {
        logic [2:0] eclk;
        tpts_pkg::tpts_ctl_t d1;
        logic d1_wr;
        logic [TW-1:0] x;
        logic [TW-1:0] y;
        logic [TW-1:0] line_len;
        logic [TW-1:0] frame_h;
        logic [TW:0] idle;
        logic vs_seen;
        logic prev_pv;
        logic prev_vs;
        logic [TW-1:0] hc;
        logic [TW-1:0] vc;
        logic [7:0] gh;
        logic [7:0] gv;
        logic [TW-1:0] gh_acc;
        logic [TW-1:0] gv_acc;
        tpts_pkg::tpts_pat_t pat;
        logic [SW-1:0] slot;
        logic [7:0] fcnt;
        logic up_ready;
        tpts_pkg::tpts_pix_t out;
        logic out_vld;
    } tpts_main_state_t;

    logic [1:0] rst_sync;
    logic rst_n;
    tpts_main_state_t st;
    tpts_main_state_t next_st;
    tpts_pkg::tpts_ctl_t src;
    tpts_pkg::tpts_ctl_t int_ctl;
    tpts_pkg::tpts_rgb_t rgb;
    tpts_pkg::tpts_pix_t fifo_out;
    logic [LW-1:0] fifo_level;
    logic fifo_vld;
    logic take;
    logic ext_mode;
    logic adv;
    logic step;
    logic frame_end;
    logic scroll_now;
    logic [SW-1:0] nxt_slot;
    logic [TW-1:0] h_last;
    logic [TW-1:0] v_last;
    logic [TW-1:0] hs_beg;
    logic [TW-1:0] vs_beg;
    logic [TW-1:0] width;
    logic [TW-1:0] height;

    // Colour bars and the empty code never take part in scrolling.
    function automatic logic scrollable(input tpts_pkg::tpts_pat_t p);
        return p != tpts_pkg::TPTS_P_NONE && p != tpts_pkg::TPTS_P_BARS;
    endfunction

    function automatic logic [SW-1:0] next_slot(
        input logic [SW-1:0] cur,
        input logic [SW-1:0] last,
        input tpts_pkg::tpts_pat_t [SLOTS-1:0] slots
    );
        logic [SW-1:0] c;
        logic [SW-1:0] res;
        logic found;
        c = cur;
        res = cur;
        found = 1'b0;
        for (int k = 0; k < SLOTS; k++)
        begin
            c = (c == last) ? '0 : c + 1'b1;
            if (!found && scrollable(slots[c]))
            begin
                res = c;
                found = 1'b1;
            end
        end
        return res;
    endfunction

    // One Bresenham step spreads full scale over a span above 256; a span of 256 or less steps by one each time.
    function automatic logic [TW+7:0] grad_step(
        input logic [7:0] g,
        input logic [TW-1:0] acc,
        input logic [TW-1:0] w
    );
        logic [TW:0] sum;
        logic [7:0] gn;
        sum = {1'b0, acc} + {1'b0, `TPTS_GRAD_STEP};
        gn = (g == `TPTS_FULL_SCALE) ? g : g + 8'h01;
        if (w <= `TPTS_GRAD_STEP)
        begin
            return {gn, {TW{1'b0}}};
        end
        if (sum >= {1'b0, w})
        begin
            sum = sum - {1'b0, w};
            return {gn, sum[TW-1:0]};
        end
        return {g, sum[TW-1:0]};
    endfunction

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_comb
    begin
        ext_mode = timing_mode_in == tpts_pkg::TPTS_TIMING_EXT;
        h_last = TW'(timing_cfg_in.h_active + timing_cfg_in.h_front
            + timing_cfg_in.h_sync + timing_cfg_in.h_back - 1'b1);
        v_last = TW'(timing_cfg_in.v_active + timing_cfg_in.v_front
            + timing_cfg_in.v_sync + timing_cfg_in.v_back - 1'b1);
        hs_beg = TW'(timing_cfg_in.h_active + timing_cfg_in.h_front);
        vs_beg = TW'(timing_cfg_in.v_active + timing_cfg_in.v_front);
        int_ctl.pixel_valid = st.hc < timing_cfg_in.h_active
            && st.vc < timing_cfg_in.v_active;
        int_ctl.horizontal_sync = st.hc >= hs_beg
            && st.hc < TW'(hs_beg + timing_cfg_in.h_sync);
        int_ctl.vertical_sync = st.vc >= vs_beg
            && st.vc < TW'(vs_beg + timing_cfg_in.v_sync);
        adv = st.up_ready
            && (timing_mode_in == tpts_pkg::TPTS_TIMING_INT
            || (timing_mode_in == tpts_pkg::TPTS_TIMING_INT_ECLK
            && st.eclk[1] && !st.eclk[2]));
        step = ext_mode || adv;
        src = ext_mode ? {pixel_valid_in, horizontal_sync_in,
            vertical_sync_in} : int_ctl;
        width = ext_mode ? st.line_len : timing_cfg_in.h_active;
        height = ext_mode ? st.frame_h : timing_cfg_in.v_active;
        if (ext_mode)
        begin
            frame_end = (vertical_sync_in && !st.prev_vs)
                || (!st.vs_seen && st.line_len != '0 && !pixel_valid_in
                && st.idle == {st.line_len, 1'b0});
        end
        else
        begin
            frame_end = adv && st.hc == h_last && st.vc == v_last;
        end
        scroll_now = frame_end && auto_scroll_in
            && st.fcnt == scroll_frames_in;
        nxt_slot = next_slot(st.slot, scroll_sequence_control_in,
            scroll_order_slots_in);

        next_st = st;
        next_st.eclk = {st.eclk[1:0], ext_pixel_clock_in};
        next_st.d1_wr = step;
        next_st.up_ready = fifo_level <= LW'(DEPTH - `TPTS_PIPE_MARGIN);
        if (!ext_mode)
        begin
            next_st.vs_seen = 1'b0;
        end
        if (adv)
        begin
            next_st.hc = (st.hc == h_last) ? '0 : st.hc + 1'b1;
            if (st.hc == h_last)
            begin
                next_st.vc = (st.vc == v_last) ? '0 : st.vc + 1'b1;
            end
        end
        if (step)
        begin
            next_st.d1 = src;
            next_st.prev_pv = src.pixel_valid;
            next_st.prev_vs = src.vertical_sync;
            next_st.idle = src.pixel_valid ? '0
                : (st.idle == '1 ? st.idle : st.idle + 1'b1);
            if (ext_mode && vertical_sync_in && !st.prev_vs)
            begin
                next_st.vs_seen = 1'b1;
            end
            if (src.pixel_valid && !st.prev_pv)
            begin
                next_st.x = '0;
                next_st.gh = '0;
                next_st.gh_acc = '0;
            end
            else if (src.pixel_valid)
            begin
                next_st.x = st.x + 1'b1;
                {next_st.gh, next_st.gh_acc} =
                    grad_step(st.gh, st.gh_acc, width);
            end
            else if (st.prev_pv)
            begin
                next_st.line_len = st.x + 1'b1;
                next_st.y = st.y + 1'b1;
                {next_st.gv, next_st.gv_acc} =
                    grad_step(st.gv, st.gv_acc, height);
            end
            if (frame_end)
            begin
                next_st.frame_h = st.y;
                next_st.y = '0;
                next_st.gv = '0;
                next_st.gv_acc = '0;
                next_st.fcnt = (scroll_now || !auto_scroll_in) ? 8'h00
                    : st.fcnt + 8'h01;
                if (!auto_scroll_in)
                begin
                    next_st.pat = pattern_select_control_in;
                end
                else if (scroll_now)
                begin
                    next_st.slot = nxt_slot;
                    next_st.pat = scrollable(scroll_order_slots_in[nxt_slot])
                        ? scroll_order_slots_in[nxt_slot] : st.pat;
                end
            end
        end

        rgb = '0;
        case (st.pat)
            tpts_pkg::TPTS_P_WHITE: rgb = {3{`TPTS_FULL_SCALE}};
            tpts_pkg::TPTS_P_RED: rgb.red = `TPTS_FULL_SCALE;
            tpts_pkg::TPTS_P_GREEN: rgb.green = `TPTS_FULL_SCALE;
            tpts_pkg::TPTS_P_BLUE: rgb.blue = `TPTS_FULL_SCALE;
            tpts_pkg::TPTS_P_HGRAY: rgb = {3{st.gh}};
            tpts_pkg::TPTS_P_HRED: rgb.red = st.gh;
            tpts_pkg::TPTS_P_HGREEN: rgb.green = st.gh;
            tpts_pkg::TPTS_P_HBLUE: rgb.blue = st.gh;
            tpts_pkg::TPTS_P_VGRAY: rgb = {3{st.gv}};
            tpts_pkg::TPTS_P_VRED: rgb.red = st.gv;
            tpts_pkg::TPTS_P_VGREEN: rgb.green = st.gv;
            tpts_pkg::TPTS_P_VBLUE: rgb.blue = st.gv;
            tpts_pkg::TPTS_P_CUSTOM: rgb = {custom_red_level_in,
                custom_green_level_in, custom_blue_level_in};
            tpts_pkg::TPTS_P_CHECKER: rgb = {3{{8{st.x[3] ^ st.y[3]}}}};
            tpts_pkg::TPTS_P_VCOM: rgb = {{8{!st.x[0]}}, {8{!st.x[1]}},
                {8{st.x[1] ^ st.x[0]}}};
            tpts_pkg::TPTS_P_BARS: rgb = {{8{!st.gh[6]}}, {8{!st.gh[7]}},
                {8{!st.gh[5]}}};
            default: rgb = '0;
        endcase
        if (pattern_invert_bit_in)
        begin
            rgb = ~rgb;
        end
        if (color_18bit_in)
        begin
            rgb = rgb & {3{`TPTS_MASK18}};
        end
        if (!st.d1.pixel_valid)
        begin
            rgb = '0;
        end

        take = fifo_vld && (!st.out_vld || link_ready_in);
        if (take)
        begin
            next_st.out = fifo_out;
            next_st.out_vld = 1'b1;
        end
        else if (link_ready_in)
        begin
            next_st.out_vld = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.pat <= tpts_pkg::TPTS_P_WHITE;
        end
        else
        begin
            st <= next_st;
        end
    end

    tpts_fifo #(.WIDTH(PW), .DEPTH(DEPTH)) u_fifo (
        .clk_in(clk_in),
        .reset_n_in(rst_n),
        .in_valid_in(st.d1_wr),
        .in_data_in({rgb, st.d1}),
        .in_ready_out(),
        .out_valid_out(fifo_vld),
        .out_data_out(fifo_out),
        .out_ready_in(take),
        .level_out(fifo_level)
    );

    assign upstream_ready_out = st.up_ready;
    assign video_out = st.out;
    assign video_valid_out = st.out_vld;
    assign frame_width_out = st.line_len;
    assign frame_height_out = st.frame_h;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n);

    ext_forward_delay_a: assert property (
        $past(rst_n) && ext_mode && $past(ext_mode)
        && $past(ext_mode, 2)
        |-> st.d1_wr && st.d1 == {$past(pixel_valid_in), $past(
        horizontal_sync_in), $past(vertical_sync_in)})
        else $error("external control not forwarded after one stage");
    invert_white_a: assert property (
        st.d1.pixel_valid && st.pat == tpts_pkg::TPTS_P_WHITE
        && pattern_invert_bit_in |-> rgb == '0)
        else $error("inverted white is not black");
    mask_low_bits_a: assert property (
        color_18bit_in |-> (rgb & ~{3{`TPTS_MASK18}}) == '0)
        else $error("low colour bits set in 18-bit mode");
    custom_colour_a: assert property (
        st.d1.pixel_valid && st.pat == tpts_pkg::TPTS_P_CUSTOM
        && !pattern_invert_bit_in && !color_18bit_in |-> rgb ==
        {custom_red_level_in, custom_green_level_in, custom_blue_level_in})
        else $error("custom colour mismatch");
    bars_not_scrolled_a: assert property (
        step && scroll_now |=> st.pat != tpts_pkg::TPTS_P_BARS)
        else $error("colour bars entered by scrolling");
    static_select_a: assert property (
        step && frame_end && !auto_scroll_in
        |=> st.pat == $past(pattern_select_control_in))
        else $error("static selection not taken at frame end");
    scroll_wrap_a: assert property (
        step && scroll_now && st.slot == scroll_sequence_control_in
        && scrollable(scroll_order_slots_in[0]) |=> st.slot == '0)
        else $error("scroll did not wrap to first slot");
    pattern_frame_only_a: assert property (
        !(step && frame_end) |=> $stable(st.pat))
        else $error("pattern changed inside a frame");
    vblank_detect_a: assert property (
        ext_mode && frame_end && !vertical_sync_in
        |-> st.idle == {st.line_len, 1'b0} && !st.vs_seen)
        else $error("blanking detected at wrong idle count");
    int_ignores_sync_a: assert property (
        timing_mode_in == tpts_pkg::TPTS_TIMING_INT && adv
        && st.hc >= timing_cfg_in.h_active |=> !st.d1.pixel_valid)
        else $error("internal timing shows valid outside active area");
    out_hold_a: assert property (
        video_valid_out && !link_ready_in
        |=> video_valid_out && $stable(video_out))
        else $error("output changed while link stalled");

    cover property (step && scroll_now
        && st.slot == scroll_sequence_control_in);
    cover property (ext_mode && frame_end && !st.vs_seen);
    cover property (timing_mode_in == tpts_pkg::TPTS_TIMING_INT_ECLK
        && frame_end);
    cover property (!upstream_ready_out);
endmodule

// ---- tpts_far_model.sv ----
// Far side of the pattern generator: link sink and external pixel clock.
// Assumes the bench steers stalls and the clock enable from its sequence.
`timescale 1ns/100ps
module tpts_far_model (
    input wire logic clk_in,
    input wire logic stall_rand_in,
    input wire logic stall_all_in,
    input wire logic eclk_en_in,
    output logic link_ready_out,
    output logic ext_pixel_clock_out
);
    int seed = 32'had27;
    initial
    begin
        link_ready_out = 1'b1;
        ext_pixel_clock_out = 1'b0;
    end
    always @(posedge clk_in)
    begin
        #1;
        link_ready_out = !stall_all_in &&
            (!stall_rand_in || ($random(seed) & 3) != 0);
    end
    // The pixel clock stands still unless enabled; its period is unrelated.
    always #7.3 ext_pixel_clock_out = eclk_en_in & !ext_pixel_clock_out;
endmodule

// ---- tpts_pattern_gen_bench.sv ----
// Self-checking bench of the pattern generator with the far side model.
// Assumes the design files and tpts_pkg are compiled first.
`timescale 1ns/100ps
module tpts_pattern_gen_bench;
    localparam int W = 8;
    localparam bit [7:0] INV_T = 8'h55;
    localparam bit [7:0] C18_T = 8'h18;
    logic clk_in, reset_n_in, eclk, up_rdy, inv, c18, scroll;
    logic link_rdy, vvalid, stall_rand, stall_all, eclk_en;
    tpts_pkg::tpts_ctl_t ctl_drv;
    tpts_pkg::tpts_mode_t mode;
    tpts_pkg::tpts_timing_cfg_t tcfg;
    tpts_pkg::tpts_pat_t sel;
    tpts_pkg::tpts_pat_t [15:0] slots;
    tpts_pkg::tpts_pix_t vout;
    tpts_pkg::tpts_pix_t exp_q[$];
    tpts_pkg::tpts_rgb_t cur, frgb;
    logic [23:0] first_q[$];
    logic [23:0] sq[4] = '{24'hff0000, 24'h0000ff, 24'hff0000, 24'h00ff00};
    logic [3:0] last_slot;
    logic [7:0] sfr, red, grn, blu;
    logic [11:0] fw, fh;
    int pnum[8] = '{1, 3, 3, 4, 5, 14, 14, 2};
    int sl[6] = '{3, 17, 5, 0, 3, 4};
    int tot_q[$], val_q[$];
    int err_total = 0, compares = 0, seed = 32'had27, cycles = 0;
    int idle = 0, tot = 0, val = 0;
    bit track = 0, wait_sync = 1, vs_used = 0, last_vs = 0, out_vs = 0;

    tpts_pattern_gen i_tpts_pattern_gen (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .ext_pixel_clock_in(eclk),
        .pixel_valid_in(ctl_drv.pixel_valid),
        .horizontal_sync_in(ctl_drv.horizontal_sync),
        .vertical_sync_in(ctl_drv.vertical_sync),
        .upstream_ready_out(up_rdy), .timing_mode_in(mode),
        .timing_cfg_in(tcfg), .pattern_invert_bit_in(inv),
        .color_18bit_in(c18), .auto_scroll_in(scroll),
        .pattern_select_control_in(sel),
        .scroll_sequence_control_in(last_slot), .scroll_frames_in(sfr),
        .scroll_order_slots_in(slots), .custom_red_level_in(red),
        .custom_green_level_in(grn), .custom_blue_level_in(blu),
        .link_ready_in(link_rdy), .video_out(vout),
        .video_valid_out(vvalid), .frame_width_out(fw),
        .frame_height_out(fh));
    tpts_far_model i_tpts_far_model (.clk_in(clk_in),
        .stall_rand_in(stall_rand), .stall_all_in(stall_all),
        .eclk_en_in(eclk_en), .link_ready_out(link_rdy),
        .ext_pixel_clock_out(eclk));

    task finish_test();
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task cmp_pix(input tpts_pkg::tpts_pix_t got, input tpts_pkg::tpts_pix_t e);
        compares++;
        if (got !== e)
        begin
            err_total++;
            $display("mismatch at %0t: word %h expected %h", $time, got, e);
        end
    endtask
    task cmp_num(input logic [23:0] got, input logic [23:0] e);
        compares++;
        if (got !== e)
        begin
            err_total++;
            $display("mismatch at %0t: value %h expected %h", $time, got, e);
        end
    endtask
    function automatic tpts_pkg::tpts_rgb_t exp_rgb();
        tpts_pkg::tpts_rgb_t c;
        case (sel)
            tpts_pkg::TPTS_P_WHITE: c = 24'hffffff;
            tpts_pkg::TPTS_P_RED: c = 24'hff0000;
            tpts_pkg::TPTS_P_GREEN: c = 24'h00ff00;
            tpts_pkg::TPTS_P_BLUE: c = 24'h0000ff;
            tpts_pkg::TPTS_P_CUSTOM: c = {red, grn, blu};
            default: c = 24'h000000;
        endcase
        if (inv)
            c = ~c;
        if (c18)
            c = c & 24'hfcfcfc;
        return c;
    endfunction
    // One upstream word per clock; the expected colour follows frame ends.
    task put(input logic v, input logic h, input logic s);
        @(posedge clk_in);
        #1;
        ctl_drv = {v, h, s};
        idle = v ? 0 : idle + 1;
        if ((s && !last_vs) || (!vs_used && idle == 2 * W + 1))
            cur = exp_rgb();
        vs_used = vs_used | s;
        last_vs = s;
        if (track)
            exp_q.push_back({v ? cur : 24'h0, v, h, s});
    endtask
    task pause(input int n);
        repeat (n) put(0, 0, 0);
    endtask
    task frame(input int use_vs, input int lines);
        for (int i = 0; i < 2 * use_vs; i++) put(0, 0, 1);
        for (int l = 0; l < lines; l++)
        begin
            for (int p = 0; p < W; p++) put(1, 0, 0);
            for (int p = 0; p < 6; p++) put(0, p < 2, 0);
        end
    endtask
    task run_int(input int n, input int fr);
        tot_q.delete();
        val_q.delete();
        repeat (n)
        begin
            @(posedge clk_in);
            #1;
            ctl_drv = 3'($random(seed));
        end
        cmp_num(tot_q.size() > fr, 1);
        for (int f = 2; f < tot_q.size(); f++)
        begin
            cmp_num(tot_q[f], 120);
            cmp_num(val_q[f], 32);
        end
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            finish_test();
        end
    end
    // Watches accepted link words, gathers frame figures and compares.
    always @(negedge clk_in)
        if (vvalid && link_rdy)
        begin
            if (vout.ctl.vertical_sync && !out_vs)
            begin
                tot_q.push_back(tot);
                val_q.push_back(val);
                first_q.push_back(frgb);
                tot = 0;
                val = 0;
            end
            out_vs = vout.ctl.vertical_sync;
            tot++;
            if (vout.ctl.pixel_valid && val++ == 0)
                frgb = vout.rgb;
            if (wait_sync && vout.ctl != 3'h0)
                wait_sync = 0;
            if (!wait_sync && exp_q.size() > 0)
                cmp_pix(vout, exp_q.pop_front());
        end

    initial
    begin
        reset_n_in = 1'b0;
        ctl_drv = 3'h0;
        mode = tpts_pkg::TPTS_TIMING_EXT;
        tcfg = {12'h8, 12'h2, 12'h2, 12'h3, 12'h4, 12'h1, 12'h1, 12'h2};
        {inv, c18, scroll, stall_rand, stall_all, eclk_en} = 6'h0;
        sel = tpts_pkg::TPTS_P_WHITE;
        last_slot = 4'h5;
        {sfr, red, grn, blu} = 32'h0;
        for (int i = 0; i < 16; i++) slots[i] = tpts_pkg::TPTS_P_BLACK;
        repeat (12) @(posedge clk_in);
        #1;
        cmp_num({vvalid, up_rdy}, 0);
        reset_n_in = 1'b1;
        repeat (8) @(posedge clk_in);
        cmp_num(up_rdy, 1);
        track = 1;
        for (int i = 0; i < 9; i++)
        begin
            sel = tpts_pkg::tpts_pat_t'(pnum[i % 8]);
            inv = INV_T[i % 8];
            c18 = C18_T[i % 8];
            {red, grn, blu} = 24'($random(seed));
            frame(1, 4);
        end
        cmp_num(fw, W);
        cmp_num(fh, 4);
        track = 0;
        pause(40);
        cmp_num(exp_q.size(), 0);
        {inv, c18} = 2'h0;
        for (int i = 0; i < 6; i++) slots[i] = tpts_pkg::tpts_pat_t'(sl[i]);
        scroll = 1;
        first_q.delete();
        repeat (9) frame(1, 2);
        scroll = 0;
        cmp_num(first_q.size(), 9);
        // Scrolling leaves slot 0 for slot 2 first, so frame f shows sq[f % 4].
        for (int f = 1; f < first_q.size(); f++)
            cmp_num(first_q[f], sq[f % 4]);
        mode = tpts_pkg::TPTS_TIMING_INT;
        stall_rand = 1;
        run_int(300, 0);
        stall_all = 1;
        repeat (40) @(posedge clk_in);
        #1;
        cmp_num({up_rdy, vvalid}, 2'h1);
        stall_all = 0;
        run_int(1200, 3);
        mode = tpts_pkg::TPTS_TIMING_INT_ECLK;
        {stall_rand, eclk_en} = 2'h1;
        run_int(3000, 3);
        {eclk_en, vs_used, idle} = 0;
        ctl_drv = 3'h0;
        mode = tpts_pkg::TPTS_TIMING_EXT;
        sel = tpts_pkg::TPTS_P_RED;
        // A full line restarts the idle count left over from internal timing.
        frame(0, 1);
        pause(40);
        exp_q.delete();
        {wait_sync, track} = 2'h3;
        frame(0, 2);
        sel = tpts_pkg::TPTS_P_BLUE;
        pause(10);
        frame(0, 1);
        pause(11);
        frame(0, 1);
        track = 0;
        pause(40);
        cmp_num(exp_q.size(), 0);
        finish_test();
    end
endmodule
